// ==== rtl/genlock_status_control_regs.sv ====
// The Avalon-MM register port was chosen for this implementation.
module genlock_status_control_regs
    import genlock_regs_pkg::*;
#(
    parameter int ADDR_W = 10
) (
    input  wire logic              core_clk,        // 100 mhz clock
    input  wire logic              resetn,          // async reset, low
    input  wire logic [ADDR_W-1:0] avs_address,     // byte address
    input  wire logic              avs_read,        // read strobe
    input  wire logic              avs_write,       // write strobe
    input  wire logic [31:0]       avs_writedata,   // write data
    input  wire logic [3:0]        avs_byteenable,  // byte lanes
    output logic      [31:0]       avs_readdata,    // read data
    output logic                   avs_waitrequest, // stall
    output logic      [1:0]        avs_response,    // 00 ok, 10 slverr
    input  wire logic              ref_valid_pin,   // valid reference seen
    input  wire logic              field_sync_input,// reference has field sync
    input  wire logic              field_locked,    // field timing locked
    input  wire logic              vert_locked,     // vertical timing locked
    input  wire logic              line_locked,     // horizontal timing locked
    input  wire logic [1:0]        pll_status,      // loop status low bits
    input  wire logic              genlock_pin,     // external genlock pin
    input  wire logic              ref_line_pulse,  // reference line start
    output logic                   lock_lost_n,     // inverse of overall lock
    output logic                   ref_lost_n,      // inverse of ref present
    output logic                   genlock_active,  // genlock request
    output logic                   drift_lock,      // 1 drift, 0 crash
    output logic                   clk_update_pulse,// load custom clock
    output logic                   ext_audio_en,    // extended audio mode
    output logic                   line_cnt_reset   // line counter reset
);
    // the decode slices bits 9:2, so narrower buses cannot be served
    if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W out of range");
    end

    logic [8:0] sync1_r, sync2_r;
    logic [6:0] ctrl_r;
    logic [15:0] line_period_r, line_default_r, line_cnt_r;
    logic        upd_prev_r, rd_done_r, wr_done_r, std_seen_r;
    logic        field_lk, clock_lk, ref_lock;
    logic [5:0]  status;
    logic [7:0]  idx;
    logic        addr_ok, hit_st, hit_ct, hit_lr, hit_ld;

    // asynchronous status inputs pass two flops first
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {ref_line_pulse, genlock_pin, pll_status,
                        line_locked, vert_locked, field_locked,
                        field_sync_input, ref_valid_pin};
            sync2_r <= sync1_r;
        end
    end

    // without field sync the field bit mirrors vertical lock
    assign field_lk = sync2_r[1] ? sync2_r[2] : sync2_r[3];
    assign clock_lk = sync2_r[5] & sync2_r[6];
    assign ref_lock = (field_lk  | ctrl_r[CT_FIELD_MASK]) &
                      (sync2_r[3] | ctrl_r[CT_VERT_MASK]) &
                      (sync2_r[4] | ctrl_r[CT_LINE_MASK]) &
                      clock_lk;
    always_comb begin
        status                 = '0;
        status[ST_REF_PRESENT] = sync2_r[0];
        status[ST_CLOCK_LOCK]  = clock_lk;
        status[ST_LINE_LOCK]   = sync2_r[4];
        status[ST_VERT_LOCK]   = sync2_r[3];
        status[ST_FIELD_LOCK]  = field_lk;
        status[ST_REF_LOCK]    = ref_lock;
    end
    assign lock_lost_n = ~ref_lock;
    assign ref_lost_n  = ~sync2_r[0];

    // address decode; index is byte address over four
    assign idx     = avs_address[9:2];
    assign addr_ok = (avs_address[1:0] == 2'b00) &&
                     ((ADDR_W == 10) || (avs_address >> 10) == '0);
    assign hit_st  = addr_ok && idx == IDX_LOCK_STATUS;
    assign hit_ct  = addr_ok && idx == IDX_CONTROL;
    assign hit_lr  = addr_ok && idx == IDX_LINE_RESET;
    assign hit_ld  = addr_ok && idx == IDX_LINE_DEFAULT;

    // one wait cycle per access keeps the answer registered
    assign avs_waitrequest = (avs_read & ~rd_done_r) |
                             (avs_write & ~wr_done_r);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rd_done_r    <= 1'b0;
            wr_done_r    <= 1'b0;
            avs_readdata <= '0;
            avs_response <= 2'b00;
        end else begin
            rd_done_r <= avs_read & ~rd_done_r;
            wr_done_r <= avs_write & ~wr_done_r;
            if (avs_read && !rd_done_r) begin
                avs_response <= 2'b00;
                if (hit_st)
                    avs_readdata <= {26'h0, status};
                else if (hit_ct)
                    avs_readdata <= {25'h0, ctrl_r};
                else if (hit_lr)
                    avs_readdata <= {16'h0, line_period_r};
                else if (hit_ld)
                    avs_readdata <= {16'h0, line_default_r};
                else begin
                    avs_readdata <= '0;
                    avs_response <= 2'b10;
                end
            end else if (avs_write && !wr_done_r) begin
                avs_response <= (hit_st | hit_ct | hit_lr | hit_ld)
                                ? 2'b00 : 2'b10;
            end
        end
    end

    // write strobe on the cycle the master sees waitrequest low
    logic wr_fire;
    assign wr_fire = avs_write & wr_done_r;

    // control; status has no write path at all
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= CONTROL_RESET;
        end else if (wr_fire && hit_ct && avs_byteenable[0]) begin
            ctrl_r <= avs_writedata[CT_WIDTH-1:0];
        end
    end

    // default per output standard, written by software at IDX_LINE_DEFAULT
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            line_default_r <= LINE_DEF_RESET;
        end else if (wr_fire && hit_ld) begin
            if (avs_byteenable[0]) line_default_r[7:0]  <= avs_writedata[7:0];
            if (avs_byteenable[1]) line_default_r[15:8] <= avs_writedata[15:8];
        end
    end

    // line period takes the standard's default until software writes it
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            line_period_r <= LINE_CNT_RESET;
            std_seen_r    <= 1'b0;
        end else if (wr_fire && hit_lr) begin
            std_seen_r <= 1'b1;
            if (avs_byteenable[0]) line_period_r[7:0]  <= avs_writedata[7:0];
            if (avs_byteenable[1]) line_period_r[15:8] <= avs_writedata[15:8];
        end else if (!std_seen_r) begin
            line_period_r <= line_default_r;
        end
    end

    // genlock source select and lock style
    assign genlock_active = ctrl_r[CT_HOST_SEL] ?
                            ctrl_r[CT_GENLOCK_REQ] : sync2_r[7];
    assign drift_lock     = ctrl_r[CT_DRIFT];
    assign ext_audio_en   = ctrl_r[CT_CLK_UPDATE];

    // rising edge of update bit makes a one-cycle load pulse
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            upd_prev_r       <= 1'b0;
            clk_update_pulse <= 1'b0;
        end else begin
            upd_prev_r       <= ctrl_r[CT_CLK_UPDATE];
            clk_update_pulse <= ctrl_r[CT_CLK_UPDATE] & ~upd_prev_r;
        end
    end

    // line counter reset, only while genlocked: every reference line when period is zero,
    // else once every programmed number of lines
    logic line_edge_prev_r, line_edge;
    assign line_edge = sync2_r[8] & ~line_edge_prev_r;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            line_edge_prev_r <= 1'b0;
            line_cnt_r       <= '0;
            line_cnt_reset   <= 1'b0;
        end else begin
            line_edge_prev_r <= sync2_r[8];
            line_cnt_reset   <= 1'b0;
            if (!genlock_active) begin
                line_cnt_r <= '0;
            end else if (line_edge) begin
                if (line_period_r == '0) begin
                    line_cnt_reset <= 1'b1;
                end else if (line_cnt_r >= line_period_r - 16'h1) begin
                    line_cnt_r     <= '0;
                    line_cnt_reset <= 1'b1;
                end else begin
                    line_cnt_r <= line_cnt_r + 16'h1;
                end
            end
        end
    end

    // checks; pin-level checks wait two edges because of the synchroniser

    // the lock pin must never disagree with the status bit
    a_lock_pin_inverse: assert property (@(posedge core_clk)
        disable iff (!resetn) lock_lost_n == ~status[ST_REF_LOCK])
        else $error("lock pin not inverse of lock");

    // overall lock needs every part held or masked
    a_overall_lock: assert property (@(posedge core_clk)
        disable iff (!resetn) status[ST_REF_LOCK] |->
        clock_lk && (field_lk || ctrl_r[CT_FIELD_MASK]) &&
        (status[ST_VERT_LOCK] || ctrl_r[CT_VERT_MASK]) &&
        (status[ST_LINE_LOCK] || ctrl_r[CT_LINE_MASK]))
        else $error("overall lock without parts");

    // all four parts held must give overall lock
    a_lock_full: assert property (@(posedge core_clk)
        disable iff (!resetn) status[ST_FIELD_LOCK] &&
        status[ST_VERT_LOCK] && status[ST_LINE_LOCK] &&
        status[ST_CLOCK_LOCK] |-> status[ST_REF_LOCK])
        else $error("overall lock missing");

    // no field sync on the reference: field bit copies vertical
    a_field_mirror: assert property (@(posedge core_clk)
        disable iff (!resetn) !sync2_r[1] |->
        status[ST_FIELD_LOCK] == status[ST_VERT_LOCK])
        else $error("field lock not mirroring vertical");

    // with field sync the field bit follows the field lock pin
    a_field_follow: assert property (@(posedge core_clk)
        disable iff (!resetn) $past(resetn, 2) &&
        $past(field_sync_input, 2) |->
        status[ST_FIELD_LOCK] == $past(field_locked, 2))
        else $error("field lock not following pin");

    // vertical bit follows its pin two edges late
    a_vert_follow: assert property (@(posedge core_clk)
        disable iff (!resetn) $past(resetn, 2) |->
        status[ST_VERT_LOCK] == $past(vert_locked, 2))
        else $error("vertical lock not following pin");

    // line bit follows its pin two edges late
    a_line_follow: assert property (@(posedge core_clk)
        disable iff (!resetn) $past(resetn, 2) |->
        status[ST_LINE_LOCK] == $past(line_locked, 2))
        else $error("line lock not following pin");

    // clock lock needs both loop bits
    a_clock_lock: assert property (@(posedge core_clk)
        disable iff (!resetn) status[ST_CLOCK_LOCK] |->
        $past(pll_status, 2) == 2'b11)
        else $error("clock lock without both loops");

    // presence bit follows its pin two edges late
    a_ref_present: assert property (@(posedge core_clk)
        disable iff (!resetn) $past(resetn, 2) |->
        status[ST_REF_PRESENT] == $past(ref_valid_pin, 2))
        else $error("ref present not following pin");

    a_ref_lost_pin: assert property (@(posedge core_clk)
        disable iff (!resetn) ref_lost_n != status[ST_REF_PRESENT])
        else $error("ref lost pin wrong");

    // a rising update bit gives exactly one load pulse
    a_update_pulse: assert property (@(posedge core_clk)
        disable iff (!resetn) $rose(ctrl_r[CT_CLK_UPDATE]) |=>
        clk_update_pulse ##1 !clk_update_pulse)
        else $error("update pulse missing");

    // a held update bit must not reload the clock
    a_pulse_single: assert property (@(posedge core_clk)
        disable iff (!resetn) clk_update_pulse |=> !clk_update_pulse)
        else $error("update pulse too long");

    // extended audio follows the written update bit
    a_audio_write: assert property (@(posedge core_clk)
        disable iff (!resetn) wr_fire && hit_ct && avs_byteenable[0] |=>
        ext_audio_en == $past(avs_writedata[CT_CLK_UPDATE]))
        else $error("audio mode not following write");

    // host select hands the request to the register bit
    a_host_request: assert property (@(posedge core_clk)
        disable iff (!resetn) ctrl_r[CT_HOST_SEL] |->
        genlock_active == ctrl_r[CT_GENLOCK_REQ])
        else $error("register request not used");

    a_host_select: assert property (@(posedge core_clk)
        disable iff (!resetn) !ctrl_r[CT_HOST_SEL] |->
        genlock_active == sync2_r[7])
        else $error("register request not ignored");

    // all three masks set: only clock lock decides
    a_all_masked: assert property (@(posedge core_clk)
        disable iff (!resetn) ctrl_r[CT_LINE_MASK] &&
        ctrl_r[CT_VERT_MASK] && ctrl_r[CT_FIELD_MASK] |->
        status[ST_REF_LOCK] == status[ST_CLOCK_LOCK])
        else $error("masked lock still counted");

    // lock style follows the written drift bit
    a_drift_write: assert property (@(posedge core_clk)
        disable iff (!resetn) wr_fire && hit_ct && avs_byteenable[0] |=>
        drift_lock == $past(avs_writedata[CT_DRIFT]))
        else $error("drift not following write");

    a_line_reset_off: assert property (@(posedge core_clk)
        disable iff (!resetn) !genlock_active |=> !line_cnt_reset)
        else $error("line reset while not genlocked");

    // zero period: every reference line resets the counter
    a_period_zero: assert property (@(posedge core_clk)
        disable iff (!resetn) genlock_active && line_edge &&
        line_period_r == '0 |=> line_cnt_reset)
        else $error("line reset missing");

    // programmed period: wrap and reset on the last line
    a_period_wrap: assert property (@(posedge core_clk)
        disable iff (!resetn) genlock_active && line_edge &&
        line_period_r != '0 && line_cnt_r >= line_period_r - 16'h1
        |=> line_cnt_reset && line_cnt_r == '0)
        else $error("period wrap missing");

    a_status_ro: assert property (@(posedge core_clk)
        disable iff (!resetn) (wr_fire && hit_st) |=>
        $stable(ctrl_r) && $stable(line_period_r))
        else $error("status write changed state");

    // answered status reads keep the unused bits clear
    a_status_upper: assert property (@(posedge core_clk)
        disable iff (!resetn) avs_read && !avs_waitrequest && hit_st |->
        avs_readdata[31:6] == '0)
        else $error("status upper bits set");
endmodule : genlock_status_control_regs

// ==== rtl/genlock_regs_pkg.sv ====
package genlock_regs_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_LOCK_STATUS  = 8'h15;
    localparam logic [7:0] IDX_CONTROL      = 8'h16;
    localparam logic [7:0] IDX_LINE_RESET   = 8'h17;
    localparam logic [7:0] IDX_LINE_DEFAULT = 8'h30;

    // status word bit positions
    localparam int ST_REF_PRESENT = 0;
    localparam int ST_CLOCK_LOCK  = 1;
    localparam int ST_LINE_LOCK   = 2;
    localparam int ST_VERT_LOCK   = 3;
    localparam int ST_FIELD_LOCK  = 4;
    localparam int ST_REF_LOCK    = 5;

    // control word bit positions
    localparam int CT_GENLOCK_REQ = 0;
    localparam int CT_DRIFT       = 1;
    localparam int CT_LINE_MASK   = 2;
    localparam int CT_VERT_MASK   = 3;
    localparam int CT_FIELD_MASK  = 4;
    localparam int CT_HOST_SEL    = 5;
    localparam int CT_CLK_UPDATE  = 6;
    localparam int CT_WIDTH       = 7;

    localparam logic [6:0]  CONTROL_RESET  = 7'h00;
    localparam logic [15:0] LINE_DEF_RESET = 16'h0000;
    localparam logic [15:0] LINE_CNT_RESET = 16'h0000;
endpackage : genlock_regs_pkg

// ==== testbench/sync_ref_model.sv ====
// stand-in for the reference source and sync detectors feeding the block
module sync_ref_model (
    input  wire logic       core_clk,         // bench clock
    input  wire logic [7:0] cfg,              // levels to present
    input  wire logic       line_on,          // run reference lines
    output logic            ref_valid_pin,    // reference seen
    output logic            field_sync_input, // reference has field sync
    output logic            field_locked,     // field locked
    output logic            vert_locked,      // vertical locked
    output logic            line_locked,      // horizontal locked
    output logic [1:0]      pll_status,       // loop lock bits
    output logic            genlock_pin,      // external request
    output logic            ref_line_pulse    // line start
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase_r = 2'h0;

    // lines four cycles apart, high for two so the synchroniser sees each
    always_ff @(posedge core_clk) begin
        phase_r <= phase_r + 2'h1;
    end
    assign ref_line_pulse   = line_on & phase_r[1];
    assign ref_valid_pin    = cfg[0];
    assign field_sync_input = cfg[1];
    assign field_locked     = cfg[2];
    assign vert_locked      = cfg[3];
    assign line_locked      = cfg[4];
    assign pll_status       = cfg[6:5];
    assign genlock_pin      = cfg[7];
endmodule : sync_ref_model

// ==== testbench/genlock_status_control_regs_tb_top.sv ====
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
miscompares++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module genlock_status_control_regs_tb_top
    import genlock_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, resetn = 0, avs_read = 0, avs_write = 0, line_on = 0;
    logic [9:0]  avs_address = 10'h000;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [1:0]  avs_response, pll_status, rsp;
    logic [7:0]  cfg = 8'h00;
    logic avs_waitrequest, ref_valid_pin, field_sync_input, field_locked;
    logic vert_locked, line_locked, genlock_pin, ref_line_pulse;
    logic lock_lost_n, ref_lost_n, genlock_active, drift_lock;
    logic clk_update_pulse, ext_audio_en, line_cnt_reset;
    int miscompares = 0, samples_checked = 0;
    int resets_seen = 0, lines_seen = 0, updates_seen = 0;

    genlock_status_control_regs #(.ADDR_W(10))
        genlock_status_control_regs_inst (
        .core_clk, .resetn, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .avs_response, .ref_valid_pin, .field_sync_input, .field_locked,
        .vert_locked, .line_locked, .pll_status, .genlock_pin,
        .ref_line_pulse, .lock_lost_n, .ref_lost_n, .genlock_active,
        .drift_lock, .clk_update_pulse, .ext_audio_en, .line_cnt_reset);
    sync_ref_model sync_ref_model_inst (.core_clk, .cfg, .line_on,
        .ref_valid_pin, .field_sync_input, .field_locked, .vert_locked,
        .line_locked, .pll_status, .genlock_pin, .ref_line_pulse);

    initial forever #5 core_clk = ~core_clk;
    // event tallies; tests compare differences, never reset these
    always @(posedge core_clk) begin
        resets_seen  <= resets_seen + int'(line_cnt_reset);
        updates_seen <= updates_seen + int'(clk_update_pulse);
        lines_seen   <= lines_seen + int'($rose(ref_line_pulse));
    end

    // one avalon transfer; held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [31:0] d);
        @(posedge core_clk);
        avs_write     <= w;
        avs_read      <= !w;
        avs_address   <= {idx, 2'b00};
        avs_writedata <= d; // upper bits always zero
        // only the watchdog ends a wait that never answers
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        rd  = avs_readdata;
        rsp = avs_response;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        repeat (6) @(posedge core_clk); // lets synced inputs settle
    endtask : bus

    function automatic logic [5:0] exp_st(input logic [7:0] c,
                                          input logic [2:0] m);
        logic f, k;
        f = c[1] ? c[2] : c[3];
        k = c[6:5] == 2'b11;
        return {(f | m[2]) & (c[3] | m[1]) & (c[4] | m[0]) & k,
                f, c[3], c[4], k, c[0]};
    endfunction : exp_st

    task automatic t_status();
        logic [7:0] tab[9] = '{8'h7f, 8'h75, 8'h75, 8'h7b, 8'h7b, 8'h6f,
                               8'h6f, 8'h5f, 8'h3e};
        logic [2:0] msk[9] = '{0, 0, 6, 0, 4, 0, 1, 7, 0};
        logic [5:0] e;
        for (int i = 0; i < 9; i++) begin
            cfg <= tab[i];
            bus(1, IDX_CONTROL, {27'h0, msk[i], 2'b00});
            e = exp_st(tab[i], msk[i]);
            bus(0, IDX_LOCK_STATUS, 0);
            `CHK("status", {26'h0, e}, rd)
            `CHK("field lock", e[4], rd[ST_FIELD_LOCK])
            `CHK("vert lock", e[3], rd[ST_VERT_LOCK])
            `CHK("line lock", e[2], rd[ST_LINE_LOCK])
            `CHK("clock lock", e[1], rd[ST_CLOCK_LOCK])
            `CHK("lock_lost_n", !e[5], lock_lost_n)
            `CHK("ref_lost_n", !e[0], ref_lost_n)
        end
        bus(1, IDX_LOCK_STATUS, 32'h3f);
        bus(0, IDX_LOCK_STATUS, 0);
        `CHK("status write", {26'h0, e}, rd)
        bus(0, 8'h40, 0);
        `CHK("unmapped resp", 2'b10, rsp)
        `CHK("unmapped data", 32'h0, rd)
    endtask : t_status

    task automatic t_ctrl();
        int u;
        cfg <= 8'h80;
        bus(1, IDX_CONTROL, 32'h00);
        `CHK("pin genlock", 1'b1, genlock_active)
        bus(1, IDX_CONTROL, 32'h20);
        `CHK("host req off", 1'b0, genlock_active)
        bus(1, IDX_CONTROL, 32'h21);
        cfg <= 8'h00;
        bus(1, IDX_CONTROL, 32'h21);
        `CHK("host req on", 1'b1, genlock_active)
        bus(1, IDX_CONTROL, 32'h03);
        `CHK("req ignored", 1'b0, genlock_active)
        `CHK("drift", 1'b1, drift_lock)
        bus(0, IDX_CONTROL, 0);
        `CHK("control rd", 32'h03, rd)
        u = updates_seen;
        bus(1, IDX_CONTROL, 32'h40);
        bus(1, IDX_CONTROL, 32'h40);
        `CHK("update count", 1, updates_seen - u)
        `CHK("ext audio", 1'b1, ext_audio_en)
        bus(1, IDX_CONTROL, 32'h00);
        `CHK("crash", 1'b0, drift_lock)
    endtask : t_ctrl

    // run k reference lines and return how many counter resets came out
    task automatic lines(input int k, output int r);
        int b, l, n;
        b = resets_seen;
        l = lines_seen;
        n = 0;
        line_on <= 1'b1;
        while (lines_seen - l < k && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        line_on <= 1'b0;
        repeat (8) @(posedge core_clk);
        r = resets_seen - b;
    endtask : lines

    task automatic t_line();
        int r;
        bus(1, IDX_LINE_DEFAULT, 32'h5);
        bus(0, IDX_LINE_RESET, 0);
        `CHK("line default", 32'h5, rd)
        bus(1, IDX_LINE_RESET, 32'h3);
        bus(1, IDX_CONTROL, 32'h21);
        lines(6, r);
        `CHK("every third", 2, r)
        bus(1, IDX_LINE_RESET, 32'h0);
        lines(3, r);
        `CHK("every line", 3, r)
        bus(1, IDX_CONTROL, 32'h00);
        lines(3, r);
        `CHK("not genlocked", 0, r)
    endtask : t_line

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize

    initial begin
        #200000;
        miscompares++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        `CHK("reset lock_lost_n", 1'b1, lock_lost_n)
        `CHK("reset ref_lost_n", 1'b1, ref_lost_n)
        resetn <= 1'b1;
        bus(0, IDX_CONTROL, 0);
        `CHK("control reset", 32'h0, rd)
        t_line();
        t_status();
        t_ctrl();
        summarize();
    end
endmodule : genlock_status_control_regs_tb_top
